// ### aip_defines.svh
`ifndef AIP_DEFINES_SVH
`define AIP_DEFINES_SVH

// register byte offsets on the 5-bit address bus
`define AIP_ADDR_MASK      5'h00
`define AIP_ADDR_STATUS    5'h04
`define AIP_ADDR_GATE      5'h08
`define AIP_ADDR_MATCH     5'h0c
`define AIP_ADDR_COUNT     5'h10
`define AIP_ADDR_OSC       5'h14

// widths and counts
`define AIP_ADDR_W         5
`define AIP_DATA_W         16
`define AIP_NARROW_W       8
`define AIP_IRQ_N          14
`define AIP_CHAN_N         10
`define AIP_RET_N          5
`define AIP_MON_N          30

// interrupt source positions
`define AIP_SRC_MATCH      0
`define AIP_SRC_VOLT_LO    1
`define AIP_SRC_VOLT_HI    10
`define AIP_SRC_CUR        11
`define AIP_SRC_TEMP       12
`define AIP_SRC_BADADDR    13

// oscillator control fields
`define AIP_OSC_MODE_HI    1
`define AIP_OSC_MODE_LO    0
`define AIP_OSC_SEL        2
`define AIP_OSC_WAKE       3

// gate driver modes, two bits per channel
`define AIP_GATE_OFF       2'h0
`define AIP_GATE_REG       2'h1
`define AIP_GATE_DIRECT    2'h2

// reset values and build-time defaults
`define AIP_RST_16         16'h0000
`define AIP_RST_14         14'h0000
`define AIP_RST_10         10'h000
`define AIP_RST_4          4'h0
`define AIP_WIDE_DATA      1'b1
`define AIP_IRQ_LOW        1'b0
`define AIP_USE_COUNTER    1'b1
`define AIP_REF_INTERNAL   1'b1
`define AIP_MON_EN         10'h3ff
`define AIP_MON_DIG        10'h000
`define AIP_GATE_CFG       20'h55555

`endif

// ### aip_pkg.sv
package aip_pkg;
   // master sequencing of one bus transfer
   typedef enum logic [1:0] {
      AIP_IDLE,
      AIP_SETUP,
      AIP_ACCESS
   } aip_apb_state_t;

   // one bit per interrupt source
   typedef logic [13:0] aip_irq_vec_t;
endpackage

// ### aip_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "aip_defines.svh"

interface aip_if;
   logic [`AIP_ADDR_W-1:0] paddr;          // register address
   logic                   psel;           // slave select
   logic                   penable;        // second transfer cycle
   logic                   pwrite;         // write when high
   logic [`AIP_DATA_W-1:0] pwdata;         // write data
   logic [`AIP_DATA_W-1:0] prdata;         // read data
   logic                   interrupt;      // polarity set at build time
   logic [`AIP_CHAN_N-1:0] voltage_monitor_in;
   logic [`AIP_CHAN_N-1:0] current_monitor_in;
   logic [`AIP_CHAN_N-1:0] temp_monitor_in;
   logic [`AIP_RET_N-1:0]  temp_monitor_return;
   logic                   counter_clock_in;
   logic [1:0]             osc_mode_out;
   logic                   osc_mode_select_out;
   logic                   ground_ref_in;
   logic                   ref_dev_o;      // device drive of reference
   logic                   ref_dev_oe;
   logic                   ref_host_o;     // external reference drive
   logic                   ref_host_oe;
   logic                   ref_level;      // resolved reference wire

   // the wire follows whichever end drives; low when nobody does
   assign ref_level = ref_dev_oe ? ref_dev_o : (ref_host_oe & ref_host_o);

   modport dev (
      input  paddr, psel, penable, pwrite, pwdata,
      output prdata, interrupt,
      input  voltage_monitor_in, current_monitor_in, temp_monitor_in,
      input  temp_monitor_return, counter_clock_in, ground_ref_in,
      output osc_mode_out, osc_mode_select_out,
      output ref_dev_o, ref_dev_oe,
      input  ref_level
   );

   modport host (
      output paddr, psel, penable, pwrite, pwdata,
      input  prdata, interrupt,
      output voltage_monitor_in, current_monitor_in, temp_monitor_in,
      output temp_monitor_return, counter_clock_in, ground_ref_in,
      input  osc_mode_out, osc_mode_select_out,
      output ref_host_o, ref_host_oe,
      input  ref_level
   );
endinterface

`default_nettype wire

// ### aip_device.sv
// Contract
// - narrow mode drives only low eight read bits
// - one interrupt output from fourteen sources
// - per-source mask bit gates each source
// - build-time parameter sets interrupt polarity
// - ports active high unless named otherwise
// - integrator ties unused monitor inputs low
// - digital monitor inputs appear on outputs
// - direct mode routes gate enables through
// - each gate output individually disableable
// - counter clock from oscillator, else low
// - integrator wires oscillator mode outputs
// - match output flags counter match event
// - separate match output wakes regulator
// - reference port drives when internal selected
// - integrator wires ground reference input
// - all logic on the bus clock
// - active-low asynchronous reset
`timescale 1ns/100ps
`default_nettype none
`include "aip_defines.svh"

module aip_device #(
   parameter bit          WIDE_DATA    = `AIP_WIDE_DATA,
   parameter bit          IRQ_LOW      = `AIP_IRQ_LOW,
   parameter bit          USE_COUNTER  = `AIP_USE_COUNTER,
   parameter bit          REF_INTERNAL = `AIP_REF_INTERNAL,
   parameter logic [9:0]  VOLT_DIG     = `AIP_MON_DIG,
   parameter logic [9:0]  CUR_DIG      = `AIP_MON_DIG,
   parameter logic [9:0]  TEMP_DIG     = `AIP_MON_DIG,
   parameter logic [19:0] GATE_CFG     = `AIP_GATE_CFG
) (
   input  wire logic        sys_clk_in,
   input  wire logic        arst_n_in,
   aip_if.dev               bus,
   input  wire logic [9:0]  direct_gate_enable_in,
   output logic      [9:0]  gate_drive_out,
   output logic      [9:0]  voltage_in_digital_out,
   output logic      [9:0]  current_in_digital_out,
   output logic      [9:0]  temp_in_digital_out,
   output logic             counter_match_out,
   output logic             regulator_wake_match_out
);

   // register state
   aip_pkg::aip_irq_vec_t  irq_mask_reg_ff;   // software source enables
   aip_pkg::aip_irq_vec_t  irq_pend_ff;       // sticky pending sources
   logic [9:0]             gate_reg_ff;       // software gate enables
   logic [15:0]            match_val_ff;      // counter compare value
   logic [15:0]            count_ff;          // counter value
   logic [3:0]             osc_ctrl_ff;       // mode, select, wake enable
   logic [15:0]            rdata_ff;          // read data, set in setup
   logic                   irq_ff;            // interrupt pin
   logic [1:0]             osc_mode_ff;
   logic                   osc_sel_ff;
   logic                   ref_oe_ff;
   logic                   match_ff;
   logic                   wake_ff;
   logic [9:0]             gate_out_ff;
   logic [29:0]            dig_out_ff;

   // pin synchronisers; meta stages feed only the sync stages
   logic [29:0]            mon_meta_ff;
   logic [29:0]            mon_sync_ff;
   logic [29:0]            mon_prev_ff;       // edge detect history
   logic                   cclk_meta_ff;
   logic                   cclk_sync_ff;
   logic                   cclk_prev_ff;

   // bus decode
   wire        wr_en   = bus.psel & bus.penable & bus.pwrite;
   wire        rd_set  = bus.psel & ~bus.penable & ~bus.pwrite;
   wire        acc_set = bus.psel & ~bus.penable;
   wire        hit_mask   = bus.paddr == `AIP_ADDR_MASK;
   wire        hit_status = bus.paddr == `AIP_ADDR_STATUS;
   wire        hit_gate   = bus.paddr == `AIP_ADDR_GATE;
   wire        hit_match  = bus.paddr == `AIP_ADDR_MATCH;
   wire        hit_count  = bus.paddr == `AIP_ADDR_COUNT;
   wire        hit_osc    = bus.paddr == `AIP_ADDR_OSC;
   wire        hit_any    = hit_mask | hit_status | hit_gate |
                            hit_match | hit_count | hit_osc;

   // narrow mode ignores the upper write byte
   wire [15:0] wdata = WIDE_DATA ? bus.pwdata :
                       {8'h00, bus.pwdata[`AIP_NARROW_W-1:0]};

   // read selection, unmapped reads return zero
   wire [15:0] rd_mux =
      hit_mask   ? {2'h0, irq_mask_reg_ff} :
      hit_status ? {2'h0, irq_pend_ff} :
      hit_gate   ? {6'h00, gate_reg_ff} :
      hit_match  ? match_val_ff :
      hit_count  ? count_ff :
      hit_osc    ? {12'h000, osc_ctrl_ff} : 16'h0000;
   wire [15:0] rd_narrow = {8'h00, rd_mux[`AIP_NARROW_W-1:0]};

   // counter tick on a synchronised rising edge of the link clock
   wire        cclk_tick = USE_COUNTER & cclk_sync_ff & ~cclk_prev_ff;
   wire        cnt_hit   = cclk_tick & (count_ff == match_val_ff);
   wire [15:0] nxt_count = cnt_hit ? 16'h0000 : count_ff + 16'h0001;

   // monitor edges, only inputs configured as digital count
   wire [29:0] mon_dig   = {TEMP_DIG, CUR_DIG, VOLT_DIG};
   wire [29:0] mon_rise  = mon_sync_ff & ~mon_prev_ff & mon_dig;

   // interrupt sources gathered into one vector
   wire aip_pkg::aip_irq_vec_t irq_src = {
      acc_set & ~hit_any,
      |mon_rise[29:20],
      |mon_rise[19:10],
      mon_rise[9:0],
      cnt_hit
   };

   // write-one-to-clear, a new event in the same cycle wins
   wire aip_pkg::aip_irq_vec_t irq_clr =
      (wr_en & hit_status) ? wdata[`AIP_IRQ_N-1:0] : `AIP_RST_14;
   wire aip_pkg::aip_irq_vec_t nxt_irq_pend =
      (irq_pend_ff & ~irq_clr) | irq_src;

   // masked sources drop out; polarity flips at build time
   wire        irq_any  = |(nxt_irq_pend & irq_mask_reg_ff);
   wire        nxt_irq  = irq_any ^ IRQ_LOW;

   // per-channel gate selection
   logic [9:0] nxt_gate;
   genvar gi;
   generate
      for (gi = 0; gi < `AIP_CHAN_N; gi = gi + 1) begin : g_gate
         wire [1:0] mode = GATE_CFG[2*gi+1:2*gi];
         assign nxt_gate[gi] =
            (mode == `AIP_GATE_DIRECT) ? direct_gate_enable_in[gi] :
            (mode == `AIP_GATE_REG)    ? gate_reg_ff[gi] :
                                         1'b0;
      end
   endgenerate

   // pin synchronisers and edge history
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mon_meta_ff  <= 30'h00000000;
         mon_sync_ff  <= 30'h00000000;
         mon_prev_ff  <= 30'h00000000;
         cclk_meta_ff <= 1'b0;
         cclk_sync_ff <= 1'b0;
         cclk_prev_ff <= 1'b0;
      end else begin
         mon_meta_ff  <= {bus.temp_monitor_in, bus.current_monitor_in,
                          bus.voltage_monitor_in};
         mon_sync_ff  <= mon_meta_ff;
         mon_prev_ff  <= mon_sync_ff;
         cclk_meta_ff <= bus.counter_clock_in;
         cclk_sync_ff <= cclk_meta_ff;
         cclk_prev_ff <= cclk_sync_ff;
      end
   end

   // software registers; writes take effect in the access cycle
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_mask_reg_ff <= `AIP_RST_14;
         gate_reg_ff     <= `AIP_RST_10;
         match_val_ff    <= `AIP_RST_16;
         osc_ctrl_ff     <= `AIP_RST_4;
      end else if (wr_en) begin
         if (hit_mask)
            irq_mask_reg_ff <= wdata[`AIP_IRQ_N-1:0];
         if (hit_gate)
            gate_reg_ff <= wdata[`AIP_CHAN_N-1:0];
         if (hit_match)
            match_val_ff <= wdata;
         if (hit_osc)
            osc_ctrl_ff <= wdata[3:0];
      end
   end

   // pending flags, interrupt pin and read data
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_pend_ff <= `AIP_RST_14;
         irq_ff      <= IRQ_LOW;
         rdata_ff    <= `AIP_RST_16;
      end else begin
         irq_pend_ff <= nxt_irq_pend;
         irq_ff      <= nxt_irq;
         // loaded in setup so it is stable through the access cycle
         if (rd_set)
            rdata_ff <= WIDE_DATA ? rd_mux : rd_narrow;
      end
   end

   // real-time counter; it holds at zero when not built in
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         count_ff <= `AIP_RST_16;
         match_ff <= 1'b0;
         wake_ff  <= 1'b0;
      end else begin
         if (cclk_tick)
            count_ff <= nxt_count;
         match_ff <= cnt_hit;
         // the regulator line only fires when software allows it
         wake_ff  <= cnt_hit & osc_ctrl_ff[`AIP_OSC_WAKE];
      end
   end

   // pin-facing outputs, all registered
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         osc_mode_ff <= 2'h0;
         osc_sel_ff  <= 1'b0;
         ref_oe_ff   <= 1'b0;
         gate_out_ff <= `AIP_RST_10;
         dig_out_ff  <= 30'h00000000;
      end else begin
         osc_mode_ff <= USE_COUNTER ?
            osc_ctrl_ff[`AIP_OSC_MODE_HI:`AIP_OSC_MODE_LO] : 2'h0;
         osc_sel_ff  <= USE_COUNTER & osc_ctrl_ff[`AIP_OSC_SEL];
         ref_oe_ff   <= REF_INTERNAL;
         gate_out_ff <= nxt_gate;
         // analog-configured channels show zero
         dig_out_ff  <= mon_sync_ff & mon_dig;
      end
   end

   assign bus.prdata              = rdata_ff;
   assign bus.interrupt           = irq_ff;
   assign bus.osc_mode_out        = osc_mode_ff;
   assign bus.osc_mode_select_out = osc_sel_ff;
   // the internal reference is modelled as a logic-high level
   assign bus.ref_dev_o           = ref_oe_ff;
   assign bus.ref_dev_oe          = ref_oe_ff;
   assign gate_drive_out          = gate_out_ff;
   assign voltage_in_digital_out  = dig_out_ff[9:0];
   assign current_in_digital_out  = dig_out_ff[19:10];
   assign temp_in_digital_out     = dig_out_ff[29:20];
   assign counter_match_out       = match_ff;
   assign regulator_wake_match_out = wake_ff;

endmodule

`default_nettype wire

// ### aip_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "aip_defines.svh"

module aip_host #(
   parameter bit          USE_COUNTER  = `AIP_USE_COUNTER,
   parameter bit          REF_INTERNAL = `AIP_REF_INTERNAL,
   parameter logic [9:0]  VOLT_EN      = `AIP_MON_EN,
   parameter logic [9:0]  CUR_EN       = `AIP_MON_EN,
   parameter logic [9:0]  TEMP_EN      = `AIP_MON_EN
) (
   input  wire logic        sys_clk_in,
   input  wire logic        arst_n_in,
   aip_if.host              bus,
   input  wire logic        cmd_valid_in,
   input  wire logic        cmd_write_in,
   input  wire logic [4:0]  cmd_addr_in,
   input  wire logic [15:0] cmd_wdata_in,
   output logic             cmd_ready_out,
   output logic             rsp_valid_out,
   output logic      [15:0] rsp_rdata_out,
   output logic             irq_out,
   input  wire logic [9:0]  volt_level_in,
   input  wire logic [9:0]  cur_level_in,
   input  wire logic [9:0]  temp_level_in,
   input  wire logic [4:0]  temp_return_in,
   input  wire logic        crystal_osc_in,
   input  wire logic        ext_ref_level_in,
   input  wire logic        ext_ground_in,
   output logic      [1:0]  osc_mode_to_osc_out,
   output logic             osc_sel_to_osc_out
);

   aip_pkg::aip_apb_state_t state_ff;
   logic                   psel_ff;
   logic                   pen_ff;
   logic                   pwr_ff;
   logic [4:0]             paddr_ff;
   logic [15:0]            pwdata_ff;
   logic                   rsp_valid_ff;
   logic [15:0]            rsp_rdata_ff;
   logic                   irq_ff;
   logic [1:0]             osc_mode_ff;
   logic                   osc_sel_ff;
   logic [29:0]            mon_ff;            // masked monitor levels
   logic [4:0]             ret_ff;
   logic                   osc_meta_ff;       // oscillator sync
   logic                   osc_sync_ff;
   logic                   cclk_ff;
   logic                   gnd_ff;
   logic                   ref_meta_ff;
   logic                   ref_sync_ff;

   // a command is only accepted while the bus is idle
   wire cmd_take = (state_ff == aip_pkg::AIP_IDLE) & cmd_valid_in;

   // bus master: setup then access, one transfer per command
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_ff     <= aip_pkg::AIP_IDLE;
         psel_ff      <= 1'b0;
         pen_ff       <= 1'b0;
         pwr_ff       <= 1'b0;
         paddr_ff     <= 5'h00;
         pwdata_ff    <= `AIP_RST_16;
         rsp_valid_ff <= 1'b0;
         rsp_rdata_ff <= `AIP_RST_16;
      end else begin
         rsp_valid_ff <= 1'b0;
         case (state_ff)
            aip_pkg::AIP_IDLE: begin
               if (cmd_take) begin
                  state_ff  <= aip_pkg::AIP_SETUP;
                  psel_ff   <= 1'b1;
                  pwr_ff    <= cmd_write_in;
                  paddr_ff  <= cmd_addr_in;
                  pwdata_ff <= cmd_wdata_in;
               end
            end
            aip_pkg::AIP_SETUP: begin
               state_ff <= aip_pkg::AIP_ACCESS;
               pen_ff   <= 1'b1;
            end
            aip_pkg::AIP_ACCESS: begin
               // the slave never stretches, so one access cycle suffices
               state_ff     <= aip_pkg::AIP_IDLE;
               psel_ff      <= 1'b0;
               pen_ff       <= 1'b0;
               rsp_valid_ff <= 1'b1;
               rsp_rdata_ff <= pwr_ff ? `AIP_RST_16 : bus.prdata;
            end
            default: begin
               state_ff <= aip_pkg::AIP_IDLE;
               psel_ff  <= 1'b0;
               pen_ff   <= 1'b0;
            end
         endcase
      end
   end

   // integrator ties and pin conditioning
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_ff      <= 1'b0;
         osc_mode_ff <= 2'h0;
         osc_sel_ff  <= 1'b0;
         mon_ff      <= 30'h00000000;
         ret_ff      <= 5'h00;
         osc_meta_ff <= 1'b0;
         osc_sync_ff <= 1'b0;
         cclk_ff     <= 1'b0;
         gnd_ff      <= 1'b0;
         ref_meta_ff <= 1'b0;
         ref_sync_ff <= 1'b0;
      end else begin
         irq_ff      <= bus.interrupt;
         // mode pins reach the oscillator only with the counter built
         osc_mode_ff <= USE_COUNTER ? bus.osc_mode_out : 2'h0;
         osc_sel_ff  <= USE_COUNTER & bus.osc_mode_select_out;
         // disabled channels are held at logic 0
         mon_ff      <= {temp_level_in & TEMP_EN, cur_level_in & CUR_EN,
                         volt_level_in & VOLT_EN};
         ret_ff      <= temp_return_in;
         osc_meta_ff <= crystal_osc_in;
         osc_sync_ff <= osc_meta_ff;
         cclk_ff     <= USE_COUNTER & osc_sync_ff;
         gnd_ff      <= ~REF_INTERNAL & ext_ground_in;
         ref_meta_ff <= ext_ref_level_in;
         ref_sync_ff <= ref_meta_ff;
      end
   end

   assign bus.psel                = psel_ff;
   assign bus.penable             = pen_ff;
   assign bus.pwrite              = pwr_ff;
   assign bus.paddr               = paddr_ff;
   assign bus.pwdata              = pwdata_ff;
   assign bus.voltage_monitor_in  = mon_ff[9:0];
   assign bus.current_monitor_in  = mon_ff[19:10];
   assign bus.temp_monitor_in     = mon_ff[29:20];
   assign bus.temp_monitor_return = ret_ff;
   assign bus.counter_clock_in    = cclk_ff;
   assign bus.ground_ref_in       = gnd_ff;
   // external reference drives the shared wire only when selected
   assign bus.ref_host_o          = ref_sync_ff;
   assign bus.ref_host_oe         = ~REF_INTERNAL;
   assign cmd_ready_out           = state_ff == aip_pkg::AIP_IDLE;
   assign rsp_valid_out           = rsp_valid_ff;
   assign rsp_rdata_out           = rsp_rdata_ff;
   assign irq_out                 = irq_ff;
   assign osc_mode_to_osc_out     = osc_mode_ff;
   assign osc_sel_to_osc_out      = osc_sel_ff;

endmodule

`default_nettype wire

// ### aip_chk.sv
`timescale 1ns/100ps
`default_nettype none

// watches the link between the host end and the device end
module aip_chk #(
   parameter bit IRQ_LOW      = 1'b0,
   parameter bit REF_INTERNAL = 1'b1
) (
   input wire logic        sys_clk_in,
   input wire logic        arst_n_in,
   input wire logic [4:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [15:0] pwdata,
   input wire logic [15:0] prdata,
   input wire logic        interrupt,
   input wire logic [1:0]  osc_mode_out,
   input wire logic        osc_mode_select_out,
   input wire logic        ground_ref_in,
   input wire logic        ref_dev_oe,
   input wire logic        ref_level
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);

   logic [13:0] mask_ff;  // shadow of the mask register
   logic [15:0] wdata_ff; // write data one cycle back
   wire  logic  acc_w = psel & penable & pwrite;          // write access
   wire  logic  bad_w = psel & ~penable & (paddr > 5'h14); // unmapped setup

   // mirror the mask so interrupt checks know which sources count
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mask_ff  <= 14'h0000;
         wdata_ff <= 16'h0000;
      end else begin
         wdata_ff <= pwdata;
         if (acc_w && paddr == 5'h00) begin
            mask_ff <= pwdata[13:0];
         end
      end
   end

   setup_hold_a: assert property (psel && !penable |=>
      psel && penable && $stable(paddr) && $stable(pwdata))
      else $error("setup not followed by a steady access");
   pen_drop_a: assert property (penable |=> !penable && !psel)
      else $error("access cycle lasted too long");
   bad_read_a: assert property (bad_w && !pwrite |=> prdata == 16'h0000)
      else $error("unmapped read returned data");
   irq_set_a: assert property (bad_w && mask_ff[13] |->
      ##[1:3] interrupt == !IRQ_LOW)
      else $error("enabled source did not raise interrupt");
   irq_mask_a: assert property ((mask_ff == 14'h0000) [*2] |->
      interrupt == IRQ_LOW)
      else $error("interrupt asserted with all sources masked");
   ref_drive_a: assert property ($past(arst_n_in) |->
      ref_dev_oe == REF_INTERNAL && (ref_level || !REF_INTERNAL))
      else $error("reference pin direction wrong");
   gnd_tie_a: assert property (REF_INTERNAL |-> ground_ref_in == 1'b0)
      else $error("ground reference not held low");
   osc_write_a: assert property (acc_w && paddr == 5'h14 |-> ##2
      osc_mode_out == wdata_ff[1:0] && osc_mode_select_out == wdata_ff[2])
      else $error("oscillator mode outputs not updated");

   cover property (acc_w);
   cover property (bad_w && mask_ff[13]);
   cover property (interrupt != IRQ_LOW);
endmodule

`default_nettype wire

// ### analog_interface_ports_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "aip_defines.svh"

// counts a compare and reports a mismatch at once
`define TB_EQ(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module analog_interface_ports_tb_top;
   logic        sys_clk_in = 1'b0;   // 125 MHz bus clock
   logic        arst_n_in  = 1'b0;   // held low for two cycles
   logic        cmd_valid  = 1'b0;   // host command strobe
   logic        cmd_write  = 1'b0;
   logic [4:0]  cmd_addr   = 5'h00;
   logic [15:0] cmd_wdata  = 16'h0000;
   logic [9:0]  direct_gate = 10'h000; // fabric gate enables
   logic [9:0]  volt_lvl = 10'h000, cur_lvl = 10'h000, temp_lvl = 10'h000;
   logic        crystal  = 1'b0;      // oscillator output to the counter
   logic        ext_gnd  = 1'b1;      // external ground pin, must be ignored
   logic        cmd_ready, rsp_valid, irq, match, wake, osc_sel;
   logic [15:0] rsp_rdata, rd;
   logic [9:0]  gate_out, volt_dig, cur_dig;
   logic [1:0]  osc_mode;
   int          fail_count = 0;
   int          checked    = 0;
   int          hits       = 0;       // match pulses seen
   int          wakes      = 0;       // regulator wake pulses seen
   localparam logic IRQ_ON = ~`AIP_IRQ_LOW; // asserted interrupt level

   always #4 sys_clk_in = ~sys_clk_in;
   // pulses last one cycle, so tally them on every edge
   always @(posedge sys_clk_in) begin
      if (match === 1'b1) hits++;
      if (wake === 1'b1) wakes++;
   end

   aip_if i_aip_if ();
   // channel 0 direct, 1 register, 2 off; voltage channel 0 digital
   aip_device #(.VOLT_DIG(10'h001), .GATE_CFG(20'h55546)) i_aip_device (
      .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .bus(i_aip_if),
      .direct_gate_enable_in(direct_gate), .gate_drive_out(gate_out),
      .voltage_in_digital_out(volt_dig), .current_in_digital_out(cur_dig),
      .temp_in_digital_out(), .counter_match_out(match),
      .regulator_wake_match_out(wake));
   // voltage channel 1 unused, so the host must hold it low
   aip_host #(.VOLT_EN(10'h3fd)) i_aip_host (
      .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .bus(i_aip_if),
      .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write),
      .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata),
      .cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid),
      .rsp_rdata_out(rsp_rdata), .irq_out(irq), .volt_level_in(volt_lvl),
      .cur_level_in(cur_lvl), .temp_level_in(temp_lvl),
      .temp_return_in(5'h00), .crystal_osc_in(crystal),
      .ext_ref_level_in(1'b0), .ext_ground_in(ext_gnd),
      .osc_mode_to_osc_out(osc_mode), .osc_sel_to_osc_out(osc_sel));
   aip_chk #(.IRQ_LOW(`AIP_IRQ_LOW)) i_aip_chk (
      .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
      .paddr(i_aip_if.paddr), .psel(i_aip_if.psel),
      .penable(i_aip_if.penable), .pwrite(i_aip_if.pwrite),
      .pwdata(i_aip_if.pwdata), .prdata(i_aip_if.prdata),
      .interrupt(i_aip_if.interrupt), .osc_mode_out(i_aip_if.osc_mode_out),
      .osc_mode_select_out(i_aip_if.osc_mode_select_out),
      .ground_ref_in(i_aip_if.ground_ref_in),
      .ref_dev_oe(i_aip_if.ref_dev_oe), .ref_level(i_aip_if.ref_level));

   task automatic stop_test();
      if (fail_count == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic ticks(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask

   // one host command; a hung handshake ends the run
   task automatic xfer(input logic wr, input logic [4:0] a,
                       input logic [15:0] d);
      int n;
      @(posedge sys_clk_in);
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_addr  <= a;
      cmd_wdata <= d;
      n = 0;
      do begin
         @(posedge sys_clk_in);
         n++;
      end while (cmd_ready !== 1'b1 && n < 16);
      cmd_valid <= 1'b0;
      do begin
         @(posedge sys_clk_in);
         n++;
      end while (rsp_valid !== 1'b1 && n < 32);
      rd = rsp_rdata;
      if (n >= 32) begin
         $display("[FAIL] %0t response timeout", $time);
         fail_count++;
         stop_test();
      end
   endtask

   task automatic t_regs();
      `TB_EQ(i_aip_if.ref_level, 1'b1)
      `TB_EQ(i_aip_if.ground_ref_in, 1'b0)
      xfer(1'b1, `AIP_ADDR_MATCH, 16'ha5c3);
      xfer(1'b0, `AIP_ADDR_MATCH, 16'h0000);
      `TB_EQ(rd, 16'ha5c3)
      xfer(1'b1, `AIP_ADDR_MASK, 16'hffff);
      xfer(1'b0, `AIP_ADDR_MASK, 16'h0000);
      `TB_EQ(rd, 16'h3fff)
   endtask

   // unmapped access raises source 13; clear it, then mask it off
   task automatic t_irq();
      xfer(1'b1, `AIP_ADDR_MASK, 16'h2000);
      xfer(1'b1, `AIP_ADDR_STATUS, 16'h3fff);
      xfer(1'b0, 5'h1c, 16'h0000);
      ticks(2);
      `TB_EQ(irq, IRQ_ON)
      xfer(1'b1, `AIP_ADDR_STATUS, 16'h2000);
      ticks(3);
      `TB_EQ(i_aip_if.interrupt, ~IRQ_ON)
      xfer(1'b1, `AIP_ADDR_MASK, 16'h0000);
      xfer(1'b1, 5'h1c, 16'hffff);
      ticks(3);
      `TB_EQ(i_aip_if.interrupt, ~IRQ_ON)
      xfer(1'b0, `AIP_ADDR_STATUS, 16'h0000);
      `TB_EQ(rd[13], 1'b1)
   endtask

   task automatic t_gate();
      xfer(1'b1, `AIP_ADDR_GATE, 16'h03ff);
      direct_gate <= 10'h3ff;
      ticks(3);
      `TB_EQ(gate_out, 10'h3fb)
      direct_gate <= 10'h000;
      ticks(3);
      `TB_EQ(gate_out, 10'h3fa)
   endtask

   // analog channels must stay quiet on the digital outputs
   task automatic t_digital();
      volt_lvl <= 10'h003;
      cur_lvl  <= 10'h3ff;
      temp_lvl <= 10'h3ff;
      ticks(6);
      `TB_EQ(volt_dig, 10'h001)
      `TB_EQ(cur_dig, 10'h000)
      `TB_EQ(i_aip_if.voltage_monitor_in, 10'h001)
   endtask

   task automatic t_counter();
      xfer(1'b1, `AIP_ADDR_MATCH, 16'h0002);
      xfer(1'b1, `AIP_ADDR_OSC, 16'h000b);
      ticks(2);
      `TB_EQ(osc_mode, 2'h3)
      hits = 0;
      wakes = 0;
      repeat (12) begin
         crystal <= ~crystal;
         ticks(4);
         `TB_EQ(i_aip_if.counter_clock_in, crystal)
      end
      ticks(8);
      `TB_EQ(hits, 2)
      `TB_EQ(wakes, hits)
   endtask

   // reset mid-run: outputs clear at once
   task automatic t_reset();
      arst_n_in <= 1'b0;
      ticks(2);
      `TB_EQ(gate_out, 10'h000)
      arst_n_in <= 1'b1;
   endtask

   initial begin
      ticks(2);
      arst_n_in <= 1'b1;
      ticks(2);
      t_regs();
      t_irq();
      t_gate();
      t_digital();
      t_counter();
      t_reset();
      stop_test();
   end
endmodule

`default_nettype wire
